// ===== inc/kde_pkg.sv
// Purpose: Shared constants and types for the keypad/display entry block.
// Assumes: 125 MHz system clock, AXI4-Lite register access, 32-bit data.
// Notes: Register byte offsets, field positions, reset values and timing counts.
package kde_pkg;

  // Register byte offsets
  localparam logic [11:0] KDE_OFF_CTRL = 12'h000;
  localparam logic [11:0] KDE_OFF_CMD = 12'h004;
  localparam logic [11:0] KDE_OFF_DATA = 12'h008;
  localparam logic [11:0] KDE_OFF_STAT = 12'h00C;

  // Control register fields
  localparam int KDE_CTRL_MODE_LSB = 0;
  localparam int KDE_CTRL_EIGHT = 2;
  localparam int KDE_CTRL_RIGHT = 3;
  localparam int KDE_CTRL_SPERR = 4;
  localparam logic [1:0] KDE_MODE_KEY = 2'h0;
  localparam logic [1:0] KDE_MODE_SENSOR = 2'h1;
  localparam logic [1:0] KDE_MODE_STROBE = 2'h2;

  // Command register fields
  localparam int KDE_CMD_AI = 4;
  localparam int KDE_CMD_LD_DISP = 5;
  localparam int KDE_CMD_LD_SENS = 6;
  localparam int KDE_CMD_END_IRQ = 7;
  localparam int KDE_CMD_FIFO_CLR = 8;
  localparam int KDE_CMD_DISP_CLR = 9;

  // Status word fields
  localparam int KDE_ST_UNDER = 4;
  localparam int KDE_ST_OVER = 5;
  localparam int KDE_ST_SE = 6;
  localparam int KDE_ST_DU = 7;

  // Sizes and reset values
  localparam logic [3:0] KDE_FIFO_DEPTH = 4'h8;
  localparam logic [7:0] KDE_BLANK_CODE = 8'h00;
  localparam logic [1:0] KDE_RESP_OKAY = 2'h0;
  localparam logic [1:0] KDE_RESP_SLVERR = 2'h2;

  // Timing: internal scan clock and display clear time
  localparam int KDE_CLK_HZ = 125000000;
  localparam int KDE_CLK_PERIOD_NS = 8;
  localparam int KDE_INT_CLK_HZ = 100000;
  localparam int KDE_DIV_CYC = KDE_CLK_HZ / KDE_INT_CLK_HZ;
  localparam int KDE_TICK_US = 1000000 / KDE_INT_CLK_HZ;
  localparam int KDE_SCAN16_TIME_US = 10300;
  localparam int KDE_SCAN16_TICKS = KDE_SCAN16_TIME_US / KDE_TICK_US;
  localparam int KDE_DIGIT_TICKS = KDE_SCAN16_TICKS / 16;
  localparam int KDE_CLEAR_TIME_NS = 160000;
  localparam int KDE_CLEAR_CYC =
    (KDE_CLEAR_TIME_NS + KDE_CLK_PERIOD_NS - 1) / KDE_CLK_PERIOD_NS;

  // Display clear sequencer states
  typedef enum logic [1:0] {
    KDE_CLR_IDLE = 2'b01,
    KDE_CLR_BUSY = 2'b10
  } kde_clr_t;

  // Whole block state
  typedef struct packed {
    logic [1:0] mode;
    logic eight;
    logic right;
    logic sperr;
    logic [3:0] disp_ptr;
    logic ai;
    logic [2:0] sens_ptr;
    logic rd_disp;
    logic [15:0][7:0] disp_ram;
    logic [3:0] rot;
    logic [7:0][7:0] sens_ram;
    logic sens_chg;
    logic sens_irq;
    logic [7:0][7:0] fifo_mem;
    logic [2:0] wp;
    logic [2:0] rp;
    logic [3:0] cnt;
    logic ovr;
    logic und;
    logic se_err;
    kde_clr_t clr_st;
    logic [14:0] clr_cnt;
    logic strb_q;
    logic [10:0] div;
    logic [5:0] dtick;
    logic [3:0] digit;
    logic [7:0] seg;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } kde_state_t;

endpackage

// ===== rtl/kde_entry.sv
// Purpose: Key/sensor/strobe data entry, display RAM entry and FIFO status.
// Assumes: Debounce and key scan timing sit outside; their events arrive as pulses, the strobe as a level whose rise is taken.
// Notes: All state sits in one struct; registers via AXI4-Lite slave.
`timescale 1ns/10ps
module kde_entry
  import kde_pkg::*;
#(
  parameter int CLEAR_CYC = KDE_CLEAR_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Matrix side
  input wire logic [3:0] scan_lines_i,
  input wire logic [7:0] return_lines_i,
  input wire logic [2:0] key_col_i,
  input wire logic ctrl_key_line_i,
  input wire logic case_key_line_i,
  input wire logic strobe_capture_line_i,
  input wire logic key_valid_i,
  input wire logic multi_closure_i,
  input wire logic sensor_sample_i,
  input wire logic sensor_scan_end_i,
  // Display and interrupt side
  output logic [3:0] disp_digit_o,
  output logic [7:0] disp_seg_o,
  output logic irq_o
);

  kde_state_t s_reg; // Registered state
  kde_state_t s_next; // Next state
  logic wr_go; // Write address and data both taken
  logic rd_go; // Read address taken

  // Write channels taken together, only while no response is pending
  assign wr_go = s_axi_awvalid_i & s_axi_wvalid_i & ~s_reg.bvalid;
  assign rd_go = s_axi_arvalid_i & ~s_reg.rvalid;
  assign s_axi_awready_o = wr_go;
  assign s_axi_wready_o = wr_go;
  assign s_axi_arready_o = ~s_reg.rvalid;
  assign s_axi_bvalid_o = s_reg.bvalid;
  assign s_axi_bresp_o = s_reg.bresp;
  assign s_axi_rvalid_o = s_reg.rvalid;
  assign s_axi_rresp_o = s_reg.rresp;
  assign s_axi_rdata_o = s_reg.rdata;
  assign disp_digit_o = s_reg.digit;
  assign disp_seg_o = s_reg.seg;

  // Interrupt: FIFO occupancy or error in key modes, change latch in sensor mode
  assign irq_o = (s_reg.mode == KDE_MODE_SENSOR) ? s_reg.sens_irq :
                 ((s_reg.cnt != 4'h0) | s_reg.se_err);

  // Pointer step within the active display width
  function automatic logic [3:0] kde_step(input logic [3:0] p, input logic eight);
    kde_step = eight ? {1'b0, p[2:0] + 3'h1} : p + 4'h1;
  endfunction

  // All next-state logic
  always_comb begin
    logic push;
    logic pop;
    logic [7:0] push_data;
    logic [3:0] pos;
    logic [11:0] wa;
    logic [11:0] ra;
    logic [7:0] stat;
    logic closure;
    push = 1'b0;
    pop = 1'b0;
    push_data = 8'h00;
    pos = 4'h0;
    wa = s_axi_awaddr_i;
    ra = s_axi_araddr_i;
    stat = 8'h00;
    closure = |s_reg.sens_ram;
    s_next = s_reg;
    s_next.strb_q = strobe_capture_line_i;

    // Response handshakes retire
    if (s_reg.bvalid && s_axi_bready_i) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.rvalid && s_axi_rready_i) begin
      s_next.rvalid = 1'b0;
    end

    // Clear sequencer: display held unavailable for the full clear time
    case (s_reg.clr_st)
      KDE_CLR_IDLE: begin
        s_next.clr_cnt = 15'h0000;
      end
      KDE_CLR_BUSY: begin
        if (s_reg.clr_cnt == 15'(CLEAR_CYC - 1)) begin
          s_next.clr_st = KDE_CLR_IDLE;
        end else begin
          s_next.clr_cnt = s_reg.clr_cnt + 15'h0001;
        end
      end
      default: begin
        s_next.clr_st = KDE_CLR_IDLE;
      end
    endcase

    // Register writes
    if (wr_go) begin
      s_next.bvalid = 1'b1;
      s_next.bresp = KDE_RESP_OKAY;
      if (wa == KDE_OFF_CTRL) begin
        if (s_axi_wstrb_i[0]) begin
          s_next.mode = s_axi_wdata_i[KDE_CTRL_MODE_LSB +: 2];
          s_next.eight = s_axi_wdata_i[KDE_CTRL_EIGHT];
          s_next.right = s_axi_wdata_i[KDE_CTRL_RIGHT];
          s_next.sperr = s_axi_wdata_i[KDE_CTRL_SPERR];
        end
      end else if (wa == KDE_OFF_CMD) begin
        if (s_axi_wstrb_i[0]) begin
          // Display pointer load also selects display as read source
          if (s_axi_wdata_i[KDE_CMD_LD_DISP]) begin
            s_next.disp_ptr = s_axi_wdata_i[3:0];
            s_next.ai = s_axi_wdata_i[KDE_CMD_AI];
            s_next.rd_disp = 1'b1;
          end
          if (s_axi_wdata_i[KDE_CMD_LD_SENS]) begin
            s_next.sens_ptr = s_axi_wdata_i[2:0];
            s_next.ai = s_axi_wdata_i[KDE_CMD_AI];
            s_next.rd_disp = 1'b0;
          end
          if (s_axi_wdata_i[KDE_CMD_END_IRQ]) begin
            s_next.sens_irq = 1'b0;
          end
        end
        if (s_axi_wstrb_i[1]) begin
          if (s_axi_wdata_i[KDE_CMD_FIFO_CLR]) begin
            s_next.cnt = 4'h0;
            s_next.wp = 3'h0;
            s_next.rp = 3'h0;
            s_next.ovr = 1'b0;
            s_next.und = 1'b0;
            s_next.se_err = 1'b0;
            s_next.sens_irq = 1'b0;
            s_next.sens_ptr = 3'h0;
          end
          if (s_axi_wdata_i[KDE_CMD_DISP_CLR]) begin
            s_next.disp_ram = {16{KDE_BLANK_CODE}};
            s_next.rot = 4'h0;
            s_next.clr_st = KDE_CLR_BUSY;
            s_next.clr_cnt = 15'h0000;
          end
        end
      end else if (wa == KDE_OFF_DATA) begin
        if (s_axi_wstrb_i[0] && s_reg.clr_st == KDE_CLR_IDLE) begin
          s_next.disp_ram[s_reg.disp_ptr] = s_axi_wdata_i[7:0];
          if (s_reg.ai) begin
            s_next.disp_ptr = kde_step(s_reg.disp_ptr, s_reg.eight);
          end
          if (s_reg.right) begin
            s_next.rot = kde_step(s_reg.rot, s_reg.eight);
          end
        end
      end else if (wa != KDE_OFF_STAT) begin
        // Unmapped address
        s_next.bresp = KDE_RESP_SLVERR;
      end
    end

    // Register reads
    if (rd_go) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = KDE_RESP_OKAY;
      s_next.rdata = 32'h0000_0000;
      if (ra == KDE_OFF_CTRL) begin
        s_next.rdata[4:0] = {s_reg.sperr, s_reg.right, s_reg.eight, s_reg.mode};
      end else if (ra == KDE_OFF_CMD) begin
        s_next.rdata[9:0] = {s_reg.rd_disp, s_reg.ai, s_reg.sens_ptr, 1'b0,
                             s_reg.disp_ptr};
      end else if (ra == KDE_OFF_DATA) begin
        if (s_reg.rd_disp) begin
          // Display RAM read shares the write pointer
          s_next.rdata[7:0] = s_reg.disp_ram[s_next.disp_ptr];
          if (s_reg.ai) begin
            s_next.disp_ptr = kde_step(s_next.disp_ptr, s_reg.eight);
          end
        end else if (s_reg.mode == KDE_MODE_SENSOR) begin
          s_next.rdata[7:0] = s_reg.sens_ram[s_reg.sens_ptr];
          if (s_reg.ai) begin
            s_next.sens_ptr = s_reg.sens_ptr + 3'h1;
          end else begin
            s_next.sens_irq = 1'b0;
          end
        end else if (s_reg.cnt == 4'h0) begin
          s_next.und = 1'b1;
        end else begin
          s_next.rdata[7:0] = s_reg.fifo_mem[s_reg.rp];
          pop = 1'b1;
        end
      end else if (ra == KDE_OFF_STAT) begin
        stat[3:0] = s_reg.cnt;
        stat[KDE_ST_UNDER] = s_reg.und;
        stat[KDE_ST_OVER] = s_reg.ovr;
        if (s_reg.sperr) begin
          stat[KDE_ST_SE] = s_reg.se_err;
        end else if (s_reg.mode == KDE_MODE_SENSOR) begin
          stat[KDE_ST_SE] = closure;
        end
        stat[KDE_ST_DU] = (s_reg.clr_st == KDE_CLR_BUSY);
        s_next.rdata[7:0] = stat;
      end else begin
        s_next.rresp = KDE_RESP_SLVERR;
      end
    end

    // Entry sources; events after a same-cycle clear still take effect
    case (s_reg.mode)
      KDE_MODE_KEY: begin
        if (s_reg.sperr && multi_closure_i) begin
          s_next.se_err = 1'b1;
        end
        if (key_valid_i) begin
          push = 1'b1;
          push_data = {ctrl_key_line_i, case_key_line_i, scan_lines_i[2:0], key_col_i};
        end
      end
      KDE_MODE_SENSOR: begin
        if (sensor_sample_i && !s_next.sens_irq) begin
          s_next.sens_ram[scan_lines_i[2:0]] = return_lines_i;
          if (s_reg.sens_ram[scan_lines_i[2:0]] != return_lines_i) begin
            s_next.sens_chg = 1'b1;
          end
        end
        if (sensor_scan_end_i && s_reg.sens_chg) begin
          s_next.sens_irq = 1'b1;
          s_next.sens_chg = 1'b0;
        end
      end
      KDE_MODE_STROBE: begin
        if (strobe_capture_line_i && !s_reg.strb_q) begin
          push = 1'b1;
          push_data = return_lines_i;
        end
      end
      default: begin
        push = 1'b0;
      end
    endcase

    // FIFO update; error flag blocks further entries
    if (push && s_next.se_err) begin
      push = 1'b0;
    end
    if (push && s_next.cnt == KDE_FIFO_DEPTH) begin
      push = 1'b0;
      s_next.ovr = 1'b1;
    end
    if (push) begin
      s_next.fifo_mem[s_next.wp] = push_data;
      s_next.wp = s_next.wp + 3'h1;
    end
    if (pop) begin
      s_next.rp = s_reg.rp + 3'h1;
    end
    s_next.cnt = s_next.cnt + {3'h0, push} - {3'h0, pop};

    // Internal 100 kHz tick and digit scan
    if (s_reg.div == 11'(KDE_DIV_CYC - 1)) begin
      s_next.div = 11'h000;
      if (s_reg.dtick == 6'(KDE_DIGIT_TICKS - 1)) begin
        s_next.dtick = 6'h00;
        s_next.digit = kde_step(s_reg.digit, s_reg.eight);
      end else begin
        s_next.dtick = s_reg.dtick + 6'h01;
      end
    end else begin
      s_next.div = s_reg.div + 11'h001;
    end

    // Left entry direct mapping; right entry rotated by write count
    pos = s_reg.right ? (s_reg.digit + s_reg.rot) : s_reg.digit;
    if (s_reg.eight) begin
      pos[3] = 1'b0;
    end
    s_next.seg = s_reg.disp_ram[pos];
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_reg <= '0;
      s_reg.clr_st <= KDE_CLR_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule

// ===== tb/kde_entry_checker.sv
// Purpose: Port assertions for kde_entry, all on the interrupt line.
// Assumes: Mode, auto_step_flag and read source are mirrored from bus writes.
// Notes: Data values are judged by the bench; these watch timing of irq.
`timescale 1ns/10ps
module kde_entry_checker
  import kde_pkg::*;
#(
  parameter int CLEAR_CYC = KDE_CLEAR_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic strobe_capture_line_i,
  input wire logic key_valid_i,
  input wire logic multi_closure_i,
  input wire logic sensor_scan_end_i,
  input wire logic irq_o
);
  logic [4:0] ctl_q; // Mirrored control field
  logic ai_q; // Mirrored auto_step_flag
  logic rdd_q; // Reads come from display RAM
  logic wr_t; // Write taken this edge
  logic rd_t; // Read taken this edge
  logic cmd_w; // Low command byte taken
  logic evt; // Any key-side event; strobe level is a safe superset
  logic km; // Keyboard mode
  logic sm; // Sensor mode
  assign wr_t = s_axi_awvalid_i && s_axi_wvalid_i && s_axi_awready_o;
  assign rd_t = s_axi_arvalid_i && s_axi_arready_o;
  assign cmd_w = wr_t && s_axi_awaddr_i == KDE_OFF_CMD && s_axi_wstrb_i[0];
  assign evt = key_valid_i || multi_closure_i || strobe_capture_line_i;
  assign km = ctl_q[1:0] == KDE_MODE_KEY;
  assign sm = ctl_q[1:0] == KDE_MODE_SENSOR;
  // Mirror the settings that decide what clears the interrupt
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctl_q <= 5'h00;
      ai_q <= 1'b0;
      rdd_q <= 1'b0;
    end else if (wr_t && s_axi_wstrb_i[0]) begin
      if (s_axi_awaddr_i == KDE_OFF_CTRL) begin
        ctl_q <= s_axi_wdata_i[4:0];
      end
      if (cmd_w && (s_axi_wdata_i[KDE_CMD_LD_DISP] || s_axi_wdata_i[KDE_CMD_LD_SENS])) begin
        ai_q <= s_axi_wdata_i[KDE_CMD_AI];
        rdd_q <= s_axi_wdata_i[KDE_CMD_LD_DISP];
      end
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Host steps seen on the bus
  sequence s_data_rd;
    rd_t && s_axi_araddr_i == KDE_OFF_DATA;
  endsequence
  sequence s_end_cmd;
    cmd_w && s_axi_wdata_i[KDE_CMD_END_IRQ];
  endsequence
  sequence s_fifo_clr;
    wr_t && s_axi_awaddr_i == KDE_OFF_CMD && s_axi_wstrb_i[1]
      && s_axi_wdata_i[KDE_CMD_FIFO_CLR];
  endsequence
  a_key_irq_set: assert property (km && key_valid_i |=> irq_o)
    else $error("key entry did not raise irq");
  a_key_irq_quiet: assert property (km && !irq_o && !evt && !wr_t |=> !irq_o)
    else $error("irq rose without a key event");
  a_strobe_irq: assert property ((ctl_q[1:0] == KDE_MODE_STROBE)
    && $rose(strobe_capture_line_i) |=> irq_o) else $error("strobe capture missed");
  a_multi_irq: assert property (km && ctl_q[KDE_CTRL_SPERR] && multi_closure_i |=> irq_o)
    else $error("multi closure did not raise irq");
  a_clear_irq: assert property ((km && !evt) ##0 s_fifo_clr |=> !irq_o)
    else $error("fifo clear left irq set");
  a_sens_quiet: assert property (sm && !irq_o && !sensor_scan_end_i && !wr_t |=> !irq_o)
    else $error("sensor irq rose outside scan end");
  a_read_clear: assert property ((sm && !ai_q && !rdd_q && !sensor_scan_end_i)
    ##0 s_data_rd |=> !irq_o) else $error("sensor read did not clear irq");
  a_end_clear: assert property ((sm && !sensor_scan_end_i) ##0 s_end_cmd |=> !irq_o)
    else $error("end interrupt did not clear irq");
endmodule
bind kde_entry kde_entry_checker #(.CLEAR_CYC(CLEAR_CYC)) u_chk (.*);

// ===== tb/kde_matrix_model.sv
// Purpose: Key matrix, sensor matrix and strobed source beside the block.
// Assumes: The bench calls its tasks; each drives just after a rising edge.
// Notes: Released lines show the inverse of their last value.
`timescale 1ns/10ps
module kde_matrix_model (
  input wire logic clk_i,
  output logic [3:0] scan_lines_o,
  output logic [7:0] return_lines_o,
  output logic [2:0] key_col_o,
  output logic ctrl_key_line_o,
  output logic case_key_line_o,
  output logic strobe_capture_line_o,
  output logic key_valid_o,
  output logic multi_closure_o,
  output logic sensor_sample_o,
  output logic sensor_scan_end_o
);
  // Quiet lines at time zero
  initial begin
    {scan_lines_o, return_lines_o, key_col_o} = 15'h0000;
    {ctrl_key_line_o, case_key_line_o, strobe_capture_line_o} = 3'h0;
    {key_valid_o, multi_closure_o, sensor_sample_o, sensor_scan_end_o} = 4'h0;
  end
  // Debounced key with its modifier levels
  task automatic key(input logic c, input logic s, input logic [2:0] r, input logic [2:0] k);
    @(posedge clk_i);
    scan_lines_o <= {1'b0, r};
    key_col_o <= k;
    ctrl_key_line_o <= c;
    case_key_line_o <= s;
    key_valid_o <= 1'b1;
    @(posedge clk_i);
    key_valid_o <= 1'b0;
    key_col_o <= ~k;
    ctrl_key_line_o <= ~c;
    case_key_line_o <= ~s;
  endtask
  // Sensor row sample; modifiers deliberately noisy
  task automatic samp(input logic [2:0] r, input logic [7:0] b, input logic c);
    @(posedge clk_i);
    scan_lines_o <= {1'b0, r};
    return_lines_o <= b;
    ctrl_key_line_o <= c;
    case_key_line_o <= ~c;
    sensor_sample_o <= 1'b1;
    @(posedge clk_i);
    sensor_sample_o <= 1'b0;
    return_lines_o <= ~b;
  endtask
  task automatic stb(input logic [7:0] b);
    @(posedge clk_i);
    return_lines_o <= b;
    strobe_capture_line_o <= 1'b1;
    @(posedge clk_i);
    @(posedge clk_i);
    strobe_capture_line_o <= 1'b0;
    return_lines_o <= ~b;
  endtask
  // One-cycle pulse: scan end when sel, else multi closure
  task automatic pls(input logic sel);
    @(posedge clk_i);
    sensor_scan_end_o <= sel;
    multi_closure_o <= ~sel;
    @(posedge clk_i);
    sensor_scan_end_o <= 1'b0;
    multi_closure_o <= 1'b0;
  endtask
endmodule

// ===== tb/testbench.sv
// Purpose: Self-checking bench for kde_entry.
// Assumes: Short display clear; reads are judged by a monitor from a queue.
// Notes: Fixed random seed; every wait is bounded.
`timescale 1ns/10ps
module testbench;
  import kde_pkg::*;
  localparam int CLR = 32; // Shortened clear time keeps the run brief
  logic clk_i, rst_b_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, irq_o;
  logic s_axi_rvalid_o, s_axi_rready_i, ctrl_key_line_i, case_key_line_i, key_valid_i;
  logic strobe_capture_line_i, multi_closure_i, sensor_sample_i, sensor_scan_end_i;
  logic [11:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i, scan_lines_i, disp_digit_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [7:0] return_lines_i, disp_seg_o, tmp;
  logic [2:0] key_col_i;
  logic [33:0] q_exp[$]; // Expected {rresp, rdata}
  logic [33:0] q_msk[$]; // Bits that matter
  logic [7:0] ref_b[0:16]; // Reference bytes
  int n_mismatch = 0;
  int compares = 0;
  int i;
  int e;
  kde_entry #(.CLEAR_CYC(CLR)) DUT (.*);
  kde_matrix_model u_mx (.clk_i, .scan_lines_o(scan_lines_i), .return_lines_o(return_lines_i),
    .key_col_o(key_col_i), .ctrl_key_line_o(ctrl_key_line_i), .case_key_line_o(case_key_line_i),
    .strobe_capture_line_o(strobe_capture_line_i), .key_valid_o(key_valid_i),
    .multi_closure_o(multi_closure_i), .sensor_sample_o(sensor_sample_i),
    .sensor_scan_end_o(sensor_scan_end_i));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Verdict and end of run
  task automatic test_done();
    $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [33:0] got, input logic [33:0] exp, input logic [33:0] m);
    compares++;
    if ((got & m) !== (exp & m)) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bounded wait for a handshake flag, checked where it is settled
  task automatic wt(ref logic s);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (s !== 1'b1 && n < 200);
    if (n >= 200) begin
      n_mismatch++;
      test_done();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
    wt(s_axi_awready_o);
    @(posedge clk_i);
    {s_axi_awvalid_i, s_axi_wvalid_i} <= 2'h0;
    wt(s_axi_bvalid_o);
    cmp({32'h0, s_axi_bresp_o}, {32'h0, r}, 34'h3);
    @(posedge clk_i);
    s_axi_bready_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] x, input logic [33:0] m = '1);
    q_exp.push_back(x);
    q_msk.push_back(m);
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
    wt(s_axi_arready_o);
    @(posedge clk_i);
    s_axi_arvalid_i <= 1'b0;
    wt(s_axi_rvalid_o);
    @(posedge clk_i);
    s_axi_rready_i <= 1'b0;
  endtask
  // Leftmost digit stays selected early in the run; its data must match the entry mode
  task automatic ck_seg(input logic [7:0] v);
    @(negedge clk_i);
    cmp({30'h0, disp_digit_o}, 34'h0, '1);
    cmp({26'h0, disp_seg_o}, {26'h0, v}, '1);
  endtask
  task automatic ck_irq(input logic v);
    @(negedge clk_i);
    cmp({33'h0, irq_o}, {33'h0, v}, 34'h1);
  endtask
  // Oldest note is the expected answer of each read
  always @(posedge clk_i) begin
    if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i === 1'b1) begin
      cmp({s_axi_rresp_o, s_axi_rdata_o}, q_exp.pop_front(), q_msk.pop_front());
    end
  end
  initial begin
    rst_b_i = 1'b0;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 5'h00;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 56'h0;
    s_axi_wstrb_i = 4'hF;
    void'($urandom(32'h9990));
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    wr(12'h010, 32'h0, KDE_RESP_SLVERR);
    rd(12'h010, {KDE_RESP_SLVERR, 32'h0}, 34'h300000000);
    // Both entry modes: 17 writes wrap onto address 0
    for (e = 0; e < 2; e++) begin
      wr(KDE_OFF_CTRL, {28'h0, e[0], 3'h0});
      wr(KDE_OFF_CMD, 32'h30);
      for (i = 0; i < 17; i++) begin
        ref_b[i] = 8'($urandom);
        wr(KDE_OFF_DATA, {24'h0, ref_b[i]});
      end
      wr(KDE_OFF_CMD, 32'h30);
      rd(KDE_OFF_DATA, {26'h0, ref_b[16]});
      for (i = 1; i < 16; i++) rd(KDE_OFF_DATA, {26'h0, ref_b[i]});
      // Left entry: slot 0 holds the wrapped 17th; right entry: oldest survivor leftmost
      ck_seg((e == 0) ? ref_b[16] : ref_b[1]);
      $display("test entry %0d done", e);
    end
    wr(KDE_OFF_CMD, 32'h25);
    wr(KDE_OFF_DATA, 32'h5A);
    wr(KDE_OFF_DATA, 32'hC3);
    rd(KDE_OFF_DATA, 34'hC3);
    rd(KDE_OFF_DATA, 34'hC3);
    $display("test fixed address done");
    wr(KDE_OFF_CMD, 32'h200);
    rd(KDE_OFF_STAT, 34'h80);
    wr(KDE_OFF_CMD, 32'h30);
    wr(KDE_OFF_DATA, 32'h77);
    repeat (CLR) @(posedge clk_i);
    rd(KDE_OFF_STAT, 34'h00);
    wr(KDE_OFF_CMD, 32'h30);
    rd(KDE_OFF_DATA, 34'h00);
    $display("test display clear done");
    wr(KDE_OFF_CTRL, 32'h0);
    wr(KDE_OFF_CMD, 32'h140);
    for (i = 0; i < 9; i++) begin
      tmp = 8'($urandom);
      ref_b[i] = tmp;
      u_mx.key(tmp[7], tmp[6], tmp[5:3], tmp[2:0]);
    end
    rd(KDE_OFF_STAT, 34'h28);
    for (i = 0; i < 8; i++) rd(KDE_OFF_DATA, {26'h0, ref_b[i]});
    rd(KDE_OFF_DATA, 34'h0, 34'h300000000);
    rd(KDE_OFF_STAT, 34'h30);
    $display("test keyboard done");
    wr(KDE_OFF_CTRL, 32'h2);
    wr(KDE_OFF_CMD, 32'h140);
    for (i = 0; i < 3; i++) begin
      ref_b[i] = 8'($urandom);
      u_mx.stb(ref_b[i]);
    end
    rd(KDE_OFF_STAT, 34'h03);
    for (i = 0; i < 3; i++) rd(KDE_OFF_DATA, {26'h0, ref_b[i]});
    $display("test strobe done");
    wr(KDE_OFF_CTRL, 32'h10);
    wr(KDE_OFF_CMD, 32'h140);
    u_mx.pls(1'b0);
    u_mx.key(1'b1, 1'b0, 3'h2, 3'h5);
    rd(KDE_OFF_STAT, 34'h40);
    wr(KDE_OFF_CMD, 32'h100);
    rd(KDE_OFF_STAT, 34'h00);
    $display("test special error done");
    wr(KDE_OFF_CTRL, 32'h1);
    wr(KDE_OFF_CMD, 32'h140);
    for (i = 0; i < 8; i++) begin
      ref_b[i] = 8'($urandom) | 8'h01;
      u_mx.samp(i[2:0], ref_b[i], i[0]);
    end
    u_mx.pls(1'b1);
    ck_irq(1'b1);
    rd(KDE_OFF_STAT, 34'h40);
    wr(KDE_OFF_CMD, 32'h50);
    for (i = 0; i < 8; i++) rd(KDE_OFF_DATA, {26'h0, ref_b[i]});
    ck_irq(1'b1);
    wr(KDE_OFF_CMD, 32'h80);
    ck_irq(1'b0);
    ref_b[3] = ~ref_b[3];
    u_mx.samp(3'h3, ref_b[3], 1'b1);
    u_mx.pls(1'b1);
    wr(KDE_OFF_CMD, 32'h43);
    rd(KDE_OFF_DATA, {26'h0, ref_b[3]});
    ck_irq(1'b0);
    $display("test sensor done");
    test_done();
  end
endmodule
